// ===== rtl/rot_pkg.sv
// Notes on behaviour
// - counter is 16-bit and counts upward
// - all-ones count wraps to zero, keeps counting
// - reload 0001h shortest, 0000h gives 65536 ticks
// - source select: peripheral, watchdog or system clock
// - peripheral/watchdog source keeps counting in stop
// - system source halts in stop, keeps state
// - stop-mode timer interrupt requests recovery and irq
// - stop wake sets stop flag and irq bit
// - halt mode does not stop an enabled timer
// - input noise filter runs in halt and stop
// - cleared enable gates counter, registers stay accessible
// - system clock source allows access anytime
// - one-shot mode counts prescaled ticks to reload
// - at reload raise interrupt, count becomes 0001h
// - at reload hardware clears enable, stops counting
// - output pulses one cycle or inverts start-to-reload
// - output feeds event system, pin when enabled
// - counter ticks on prescaled timer clock
// - prescaler divides by 1 up to 128
package rot_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] ROT_ADDR_CTRL = 4'h0;
  localparam logic [3:0] ROT_ADDR_COUNT = 4'h4;
  localparam logic [3:0] ROT_ADDR_RELOAD = 4'h8;
  localparam logic [3:0] ROT_ADDR_STATUS = 4'hC;
  // ==========================================================
  // control field positions
  localparam int ROT_CTL_EN = 0;
  localparam int ROT_CTL_POL = 1;
  localparam int ROT_CTL_OUTPUT_BEHAVIOUR_SELECT = 2;
  localparam int ROT_CTL_PRES = 3;
  localparam int ROT_CTL_CLKS = 6;
  localparam int ROT_CTL_MODE = 8;
  localparam int ROT_CTL_ICFG = 12;
  localparam int ROT_CTL_IEN = 14;
  localparam int ROT_CTL_FEN = 15;
  localparam int ROT_CTL_PINEN = 16;
  localparam int ROT_CTL_W = 17;
  // ==========================================================
  // status field positions
  localparam int ROT_ST_IRQ = 0;
  localparam int ROT_ST_STOP = 1;
  localparam int ROT_ST_IN0 = 2;
  localparam int ROT_ST_CAP = 3;
  // ==========================================================
  // reset values
  localparam logic [16:0] ROT_CTRL_RST = 17'h00000;
  localparam logic [15:0] ROT_COUNT_RST = 16'h0000;
  localparam logic [15:0] ROT_RELOAD_RST = 16'h0000;
  localparam logic [15:0] ROT_COUNT_AFTER_RELOAD = 16'h0001;
  // ==========================================================
  // encodings
  localparam logic [1:0] ROT_SRC_SYS = 2'h0;
  localparam logic [1:0] ROT_SRC_PCLK = 2'h1;
  localparam logic [1:0] ROT_SRC_WDOSC = 2'h2;
  localparam logic [3:0] ROT_MODE_ONESHOT = 4'h0;
  localparam logic [1:0] ROT_RESP_OKAY = 2'h0;
  localparam logic [1:0] ROT_RESP_SLVERR = 2'h2;
  // ==========================================================
  // timing
  localparam int ROT_SYNC_STAGES = 3;
  localparam int ROT_FILT_NS = 160;
  localparam int ROT_CLK_MHZ = 25;
  localparam int ROT_FILT_CYC_I =
    (ROT_FILT_NS * ROT_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] ROT_FILT_CYC = ROT_FILT_CYC_I[3:0];
endpackage : rot_pkg

// ===== rtl/rot_timer.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module rot_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic peripheral_clock_in,
  input wire logic watchdog_oscillator_clock,
  input wire logic timer_input0,
  output logic timer_irq,
  output logic stop_recovery_req,
  output logic timer_event_out,
  output logic timer_pin_out,
  output logic timer_pin_oe
);
  import rot_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] sync_a_r;
  logic [2:0] sync_b_r;
  logic [2:0] sync_c_r;
  logic [2:0] pin_lvl_r;
  logic [2:0] pin_rise;

  assign pin_raw = {timer_input0, watchdog_oscillator_clock,
                    peripheral_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < ROT_SYNC_STAGES; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_a_r[gi] <= 1'b0;
          sync_b_r[gi] <= 1'b0;
          sync_c_r[gi] <= 1'b0;
          pin_lvl_r[gi] <= 1'b0;
        end else begin
          sync_a_r[gi] <= pin_raw[gi];
          sync_b_r[gi] <= sync_a_r[gi];
          sync_c_r[gi] <= sync_b_r[gi];
          // a change counts only once two stages agree
          if (sync_b_r[gi] == sync_c_r[gi]) begin
            pin_lvl_r[gi] <= sync_c_r[gi];
          end
        end
      end
      assign pin_rise[gi] = (sync_b_r[gi] == sync_c_r[gi]) &&
                            sync_c_r[gi] && !pin_lvl_r[gi];
    end
  endgenerate

  // ==========================================================
  // registers
  logic [16:0] ctrl_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic irq_pend_r;
  logic stop_flag_r;
  logic in0_filt_r;
  logic [3:0] filt_cnt_r;
  logic [6:0] pres_cnt_r;
  logic out_pulse_r;

  logic en;
  logic pol;
  logic output_behaviour_select;
  logic [2:0] pres;
  logic [1:0] clks;
  logic [3:0] mode;
  logic ien;
  logic fen;
  logic pin_en;

  assign en = ctrl_r[ROT_CTL_EN];
  assign pol = ctrl_r[ROT_CTL_POL];
  assign output_behaviour_select = ctrl_r[ROT_CTL_OUTPUT_BEHAVIOUR_SELECT];
  assign pres = ctrl_r[ROT_CTL_PRES +: 3];
  assign clks = ctrl_r[ROT_CTL_CLKS +: 2];
  assign mode = ctrl_r[ROT_CTL_MODE +: 4];
  assign ien = ctrl_r[ROT_CTL_IEN];
  assign fen = ctrl_r[ROT_CTL_FEN];
  assign pin_en = ctrl_r[ROT_CTL_PINEN];

  // ==========================================================
  // timer clock selection and prescaler
  logic src_edge;
  logic pres_term;
  logic tick;
  logic reload_hit;
  logic [6:0] pres_max;

  always_comb begin
    case (clks)
      ROT_SRC_SYS: src_edge = !stop_mode;
      ROT_SRC_PCLK: src_edge = pin_rise[0];
      ROT_SRC_WDOSC: src_edge = pin_rise[1];
      default: src_edge = 1'b0;
    endcase
  end

  // halt_mode is deliberately not a term here
  assign pres_max = 7'((8'h01 << pres) - 8'h01);
  assign pres_term = en && src_edge && (pres_cnt_r == pres_max);
  assign tick = pres_term;
  // hit on the tick that brings the count to reload: (reload-start) ticks
  assign reload_hit = tick && (mode == ROT_MODE_ONESHOT) &&
                      (count_r + 16'h0001 == reload_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pres_cnt_r <= 7'h00;
    end else if (!en) begin
      pres_cnt_r <= 7'h00;
    end else if (src_edge) begin
      if (pres_cnt_r == pres_max) begin
        pres_cnt_r <= 7'h00;
      end else begin
        pres_cnt_r <= pres_cnt_r + 7'h01;
      end
    end
  end

  // ==========================================================
  // bus slave
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic wr_ok;
  logic [31:0] wr_merged;
  logic [31:0] wr_old;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_ok = (aw_addr_r[1:0] == 2'h0) &&
                 (aw_addr_r != ROT_ADDR_STATUS ||
                  aw_addr_r == ROT_ADDR_STATUS);

  always_comb begin
    case (aw_addr_r)
      ROT_ADDR_CTRL: wr_old = {15'h0000, ctrl_r};
      ROT_ADDR_COUNT: wr_old = {16'h0000, count_r};
      ROT_ADDR_RELOAD: wr_old = {16'h0000, reload_r};
      default: wr_old = 32'h00000000;
    endcase
    for (int b = 0; b < 4; b++) begin
      wr_merged[b*8 +: 8] = w_strb_r[b] ? w_data_r[b*8 +: 8]
                                         : wr_old[b*8 +: 8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ROT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r[1:0] == 2'h0) ? ROT_RESP_OKAY
                                                : ROT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl;
  logic wr_count;
  logic wr_reload;
  logic wr_status;

  assign wr_ctrl = wr_go && wr_ok && aw_addr_r == ROT_ADDR_CTRL;
  assign wr_count = wr_go && wr_ok && aw_addr_r == ROT_ADDR_COUNT;
  assign wr_reload = wr_go && wr_ok &&
                     aw_addr_r == ROT_ADDR_RELOAD;
  assign wr_status = wr_go && wr_ok &&
                     aw_addr_r == ROT_ADDR_STATUS;

  // ==========================================================
  // control register; enable cleared by one-shot reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ROT_CTRL_RST;
    end else if (wr_ctrl) begin
      // a software write always reaches the register
      ctrl_r <= wr_merged[ROT_CTL_W-1:0];
    end else if (reload_hit) begin
      ctrl_r[ROT_CTL_EN] <= 1'b0;
    end
  end

  // ==========================================================
  // counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= ROT_COUNT_RST;
    end else if (wr_count) begin
      count_r <= wr_merged[15:0];
    end else if (reload_hit) begin
      count_r <= ROT_COUNT_AFTER_RELOAD;
    end else if (tick) begin
      // natural wrap at all-ones; reload 0 runs 65536 ticks
      count_r <= count_r + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_r <= ROT_RELOAD_RST;
    end else if (wr_reload) begin
      reload_r <= wr_merged[15:0];
    end
  end

  // ==========================================================
  // interrupt and stop-mode wake flags, write one to clear
  logic irq_event;
  assign irq_event = reload_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pend_r <= 1'b0;
      stop_flag_r <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      if (irq_event) begin
        irq_pend_r <= 1'b1;
      end else if (wr_status && w_strb_r[0] &&
                   w_data_r[ROT_ST_IRQ]) begin
        irq_pend_r <= 1'b0;
      end
      if (irq_event && ien && stop_mode) begin
        stop_flag_r <= 1'b1;
      end else if (wr_status && w_strb_r[0] &&
                   w_data_r[ROT_ST_STOP]) begin
        stop_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_recovery_req <= 1'b0;
    end else begin
      stop_recovery_req <= irq_event && ien && stop_mode;
    end
  end

  assign timer_irq = irq_pend_r && ien;

  // ==========================================================
  // input noise filter, independent of halt and stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_cnt_r <= 4'h0;
      in0_filt_r <= 1'b0;
    end else if (!fen) begin
      filt_cnt_r <= 4'h0;
      in0_filt_r <= pin_lvl_r[2];
    end else if (pin_lvl_r[2] == in0_filt_r) begin
      filt_cnt_r <= 4'h0;
    end else if (filt_cnt_r == ROT_FILT_CYC) begin
      // glitches shorter than the window never pass
      in0_filt_r <= pin_lvl_r[2];
      filt_cnt_r <= 4'h0;
    end else begin
      filt_cnt_r <= filt_cnt_r + 4'h1;
    end
  end

  // ==========================================================
  // timer output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_pulse_r <= 1'b0;
      timer_event_out <= 1'b0;
    end else begin
      out_pulse_r <= reload_hit;
      if (output_behaviour_select) begin
        timer_event_out <= pol ^ en;
      end else begin
        timer_event_out <= pol ^ reload_hit;
      end
    end
  end

  assign timer_pin_out = timer_event_out;
  assign timer_pin_oe = pin_en;

  // ==========================================================
  // read channel
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ROT_ADDR_CTRL: rd_val = {15'h0000, ctrl_r};
      ROT_ADDR_COUNT: rd_val = {16'h0000, count_r};
      ROT_ADDR_RELOAD: rd_val = {16'h0000, reload_r};
      ROT_ADDR_STATUS: rd_val = {28'h0000000, 1'b0, in0_filt_r,
                                 stop_flag_r, irq_pend_r};
      default: begin
        rd_val = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ROT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? ROT_RESP_OKAY : ROT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic unused_ok;
  assign unused_ok = halt_mode ^ out_pulse_r;
endmodule : rot_timer

// ===== tb/rot_timer_assertions.sv
`timescale 1ns/1ps
module rot_timer_assertions (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic timer_irq,
  input logic stop_recovery_req,
  input logic timer_event_out,
  input logic timer_pin_out,
  input logic timer_pin_oe
);
  import rot_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // register bus
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (s_wr_both |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_answer: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  // ==========================================================
  // timer outputs
  chk_recov_pulse: assert property (
    stop_recovery_req |=> !stop_recovery_req)
    else $error("recovery request longer than one cycle");
  chk_recov_irq: assert property (
    stop_recovery_req |-> ##[0:1] timer_irq)
    else $error("recovery without interrupt");
  chk_pin_event: assert property (
    timer_pin_out == timer_event_out)
    else $error("pin differs from event output");
  chk_oe_by_write: assert property (
    $changed(timer_pin_oe) |-> s_axi_bvalid)
    else $error("pin enable changed without write");
endmodule : rot_timer_assertions

bind rot_timer rot_timer_assertions u_chk (.*);

// ===== tb/rot_timer_test.sv
`timescale 1ns/1ps
module rot_timer_test;
  import rot_pkg::*;
  logic aclk, aresetn, halt_mode, stop_mode, timer_input0;
  logic peripheral_clock_in, watchdog_oscillator_clock;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic timer_irq, stop_recovery_req, timer_event_out;
  logic timer_pin_out, timer_pin_oe;
  int bad_count = 0;
  int cmp_count = 0;
  int hi_cnt = 0;
  int div = 0;
  int d0, d, rs;
  bit lazy = 1;
  rot_timer uut (.*);
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  // ==========================================================
  // free-running far-side clocks, slower than the synchronisers
  always @(posedge aclk) begin
    div <= div + 1;
    hi_cnt <= hi_cnt + int'(timer_event_out === 1'b1);
    if (div % 3 == 0) peripheral_clock_in <= !peripheral_clock_in;
    if (div % 5 == 0) watchdog_oscillator_clock <= !watchdog_oscillator_clock;
  end
  // ==========================================================
  // helpers
  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int n, dly;
    logic ga, gw, gb;
    n = 0;
    gb = 0;
    dly = lazy ? $urandom_range(0, 4) : 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!gb && n < 100) begin
      @(negedge aclk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid && s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= !gb && n >= dly;
    end
    if (!gb) bad_count++;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int n, dly;
    logic ga, gr;
    n = 0;
    gr = 0;
    dly = lazy ? $urandom_range(0, 3) : 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!gr && n < 100) begin
      @(negedge aclk);
      ga = s_axi_arvalid && s_axi_arready;
      gr = s_axi_rvalid && s_axi_rready;
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ga) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !gr && n >= dly;
    end
    if (!gr) bad_count++;
  endtask : rd
  function automatic logic [31:0] ctl(input logic [2:0] p, input logic oc,
                                      input logic [1:0] src);
    logic [31:0] c;
    c = 32'h0;
    c[ROT_CTL_PRES+:3] = p;
    c[ROT_CTL_OUTPUT_BEHAVIOUR_SELECT] = oc;
    c[ROT_CTL_CLKS+:2] = src;
    c[ROT_CTL_MODE+:4] = ROT_MODE_ONESHOT;
    c[ROT_CTL_IEN] = 1'b1;
    c[ROT_CTL_PINEN] = 1'b1;
    return c;
  endfunction : ctl
  function automatic int ticks(input logic [15:0] s, r, input logic [2:0] p);
    logic [15:0] sp;
    sp = r - s;
    return (sp == 16'h0 ? 65536 : int'(sp)) << p;
  endfunction : ticks
  // one one-shot run; returns cycles from enable write to interrupt
  task automatic run(input logic [15:0] s, r, input logic [2:0] p,
                     input logic oc, output int dd);
    int h;
    wr(ROT_ADDR_STATUS, 32'h3);
    chk("irq_clear", timer_irq, 1'b0);
    wr(ROT_ADDR_CTRL, ctl(p, oc, ROT_SRC_SYS));
    wr(ROT_ADDR_COUNT, {16'h0, s});
    wr(ROT_ADDR_RELOAD, {16'h0, r});
    h = hi_cnt;
    dd = 0;
    lazy = 0;
    wr(ROT_ADDR_CTRL, ctl(p, oc, ROT_SRC_SYS) | 32'h1);
    lazy = 1;
    while (timer_irq !== 1'b1 && dd < 40000) begin
      @(negedge aclk);
      dd++;
    end
    repeat (3) @(posedge aclk);
    rd(ROT_ADDR_COUNT);
    chk("count_after", rd_d, ROT_COUNT_AFTER_RELOAD);
    rd(ROT_ADDR_CTRL);
    chk("enable_after", rd_d[ROT_CTL_EN], 1'b0);
    chk("pulse_len", hi_cnt - h, oc ? ticks(s, r, p) : 1);
    chk("out_idle", timer_event_out, 1'b0);
  endtask : run
  task automatic stop_run(input logic [1:0] src);
    int n;
    wr(ROT_ADDR_STATUS, 32'h3);
    wr(ROT_ADDR_CTRL, ctl(3'h0, 1'b0, src));
    wr(ROT_ADDR_COUNT, 32'h1);
    wr(ROT_ADDR_RELOAD, 32'h3);
    stop_mode <= 1'b1;
    wr(ROT_ADDR_CTRL, ctl(3'h0, 1'b0, src) | 32'h1);
    n = 0;
    while (stop_recovery_req !== 1'b1 && n < 80) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    if (src == ROT_SRC_SYS) begin
      rd(ROT_ADDR_COUNT);
      chk("stop_hold", rd_d, 32'h1);
      stop_mode <= 1'b0;
      repeat (20) @(posedge aclk);
      chk("resume_irq", timer_irq, 1'b1);
      rd(ROT_ADDR_STATUS);
      chk("no_wake", rd_d[ROT_ST_STOP], 1'b0);
    end else begin
      chk("wake_req", n < 80, 1'b1);
      stop_mode <= 1'b0;
      rd(ROT_ADDR_STATUS);
      chk("wake_flags", rd_d[1:0], 2'h3);
    end
  endtask : stop_run
  task automatic timed(input logic [15:0] s, r, input logic [2:0] p,
                       input logic oc);
    halt_mode <= 1'($urandom_range(0, 1));
    run(s, r, p, oc, d);
    chk("timeout", d - d0, ticks(s, r, p) - 1);
  endtask : timed
  // ==========================================================
  // watchdog
  initial begin
    #(40 * 60000);
    bad_count++;
    close_out();
  end
  initial begin
    aresetn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, halt_mode, stop_mode} = 4'h0;
    {timer_input0, peripheral_clock_in, watchdog_oscillator_clock} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    rs = $urandom(35);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe_reset", timer_pin_oe, 1'b0);
    for (int a = 0; a < 16; a += 4) begin
      rd(4'(a));
      chk("reset_val", rd_d, 32'h0);
    end
    wr(4'h1, 32'hFFFF);
    chk("wr_unaligned", rsp, ROT_RESP_SLVERR);
    rd(4'h6);
    chk("rd_unaligned", rd_d, 32'h0);
    chk("rd_unaligned_resp", rsp, ROT_RESP_SLVERR);
    repeat (6) begin
      rs = $urandom;
      wr(ROT_ADDR_COUNT, rs);
      rd(ROT_ADDR_COUNT);
      chk("count_rw", rd_d, {16'h0, rs[15:0]});
      wr(ROT_ADDR_RELOAD, ~rs);
      rd(ROT_ADDR_RELOAD);
      chk("reload_rw", rd_d, {16'h0, ~rs[15:0]});
    end
    run(16'h0000, 16'h0001, 3'h0, 1'b0, d0);
    chk("oe_set", timer_pin_oe, 1'b1);
    timed(16'hFFF0, 16'h0000, 3'h0, 1'b0);
    timed(16'h0005, 16'h0007, 3'h7, 1'b1);
    repeat (5) begin
      rs = $urandom_range(0, 200);
      timed(16'(rs), 16'(rs + $urandom_range(1, 40)),
            3'($urandom_range(0, 3)), 1'($urandom_range(0, 1)));
    end
    stop_run(ROT_SRC_SYS);
    stop_run(ROT_SRC_PCLK);
    stop_run(ROT_SRC_WDOSC);
    // free-running mode wraps past all-ones
    wr(ROT_ADDR_COUNT, 32'hFFFF);
    lazy = 0;
    wr(ROT_ADDR_CTRL, ctl(3'h0, 1'b0, ROT_SRC_SYS) | 32'h101);
    wr(ROT_ADDR_CTRL, ctl(3'h0, 1'b0, ROT_SRC_SYS) | 32'h100);
    lazy = 1;
    rd(ROT_ADDR_COUNT);
    // three ticks fit between two back-to-back control writes
    chk("wrap", rd_d, 32'h2);
    // filtered input in halt and stop
    halt_mode <= 1'b1;
    stop_mode <= 1'b1;
    wr(ROT_ADDR_CTRL, ctl(3'h0, 1'b0, ROT_SRC_SYS) | (32'h1 << ROT_CTL_FEN));
    timer_input0 <= 1'b1;
    // long enough to pass the synchroniser, short of the filter window
    repeat (3) @(posedge aclk);
    timer_input0 <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(ROT_ADDR_STATUS);
    chk("glitch", rd_d[ROT_ST_IN0], 1'b0);
    timer_input0 <= 1'b1;
    repeat (12) @(posedge aclk);
    rd(ROT_ADDR_STATUS);
    chk("steady", rd_d[ROT_ST_IN0], 1'b1);
    close_out();
  end
endmodule : rot_timer_test
